// File: hdl/tsto_unit.sv
// execution unit for test-and-set, software trap, conditional trap and overflow trap
// assumes an apb master sets up opword and context, then writes go; memory answers with mem_ack
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module tsto_unit #(
  parameter int DATA_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_lock,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic irq
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (DATA_W != 32) begin : g_bad_width
    $error("tsto_unit serves a 32-bit data path only");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tsto_pkg::tsto_state_type state_reg, state_next;
  logic [15:0] opword_reg, opword_next;
  logic [31:0] pc_reg, pc_next;
  logic [31:0] ssp_reg, ssp_next;
  logic [15:0] sr_reg, sr_next;
  logic [31:0] ea_reg, ea_next;
  logic [31:0] data_opnd_reg, data_opnd_next;
  logic [31:0] vbr_reg, vbr_next;
  logic [31:0] saved_pc_reg, saved_pc_next;
  logic [7:0] vec_reg, vec_next;
  logic [2:0] result_reg, result_next;
  logic [tsto_pkg::EV_W-1:0] irq_stat_reg, irq_stat_next;
  logic [tsto_pkg::EV_W-1:0] irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic mem_req_reg, mem_req_next;
  logic mem_we_reg, mem_we_next;
  logic mem_lock_reg, mem_lock_next;
  logic [1:0] mem_size_reg, mem_size_next;
  logic [31:0] mem_addr_reg, mem_addr_next;
  logic [31:0] mem_wdata_reg, mem_wdata_next;

  // ------------------------------------------------------------
  // condition evaluation
  // ------------------------------------------------------------
  function automatic logic cond_true(input logic [3:0] cc, input logic [15:0] sr);
    logic c;
    logic v;
    logic z;
    logic n;
    logic r;
    c = sr[tsto_pkg::FLAG_C];
    v = sr[tsto_pkg::FLAG_V];
    z = sr[tsto_pkg::FLAG_Z];
    n = sr[tsto_pkg::FLAG_N];
    unique case (cc)
      4'h0: r = 1'b1;
      4'h1: r = 1'b0;
      4'h2: r = ~c & ~z;
      4'h3: r = c | z;
      4'h4: r = ~c;
      4'h5: r = c;
      4'h6: r = ~z;
      4'h7: r = z;
      4'h8: r = ~v;
      4'h9: r = v;
      4'hA: r = ~n;
      4'hB: r = n;
      4'hC: r = n == v;
      4'hD: r = n != v;
      4'hE: r = (n == v) & ~z;
      4'hF: r = z | (n != v);
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [2:0] ea_mode;
  logic [2:0] ea_regno;
  logic is_tas;
  logic tas_legal;
  logic is_trap;
  logic is_overflow_trap_op;
  logic is_conditional_trap_op;
  logic conditional_trap_op_legal;
  logic [31:0] conditional_trap_op_len;
  logic [7:0] trap_vec;

  always_comb begin
    ea_mode = opword_reg[5:3];
    ea_regno = opword_reg[2:0];
    is_tas = opword_reg[15:6] == tsto_pkg::TAS_MATCH;
    // address register direct, immediate and pc-relative forms are refused
    tas_legal = (ea_mode != tsto_pkg::MODE_AREG && ea_mode != tsto_pkg::MODE_EXT) ||
      (ea_mode == tsto_pkg::MODE_EXT && ea_regno <= tsto_pkg::REG_ABS_LONG);
    is_trap = opword_reg[15:4] == tsto_pkg::TRAP_MATCH;
    is_overflow_trap_op = opword_reg == tsto_pkg::OVERFLOW_TRAP_OP_OPWORD;
    is_conditional_trap_op = opword_reg[15:12] == tsto_pkg::CONDITIONAL_TRAP_OP_TOP &&
      opword_reg[7:3] == tsto_pkg::CONDITIONAL_TRAP_OP_MID;
    conditional_trap_op_legal = opword_reg[2:0] == tsto_pkg::CONDITIONAL_TRAP_OP_ONE_WORD ||
      opword_reg[2:0] == tsto_pkg::CONDITIONAL_TRAP_OP_TWO_WORD || opword_reg[2:0] == tsto_pkg::CONDITIONAL_TRAP_OP_NO_WORD;
    // length of the whole conditional trap, opword plus operand words
    if (opword_reg[2:0] == tsto_pkg::CONDITIONAL_TRAP_OP_ONE_WORD) begin
      conditional_trap_op_len = tsto_pkg::STEP_WORD + tsto_pkg::STEP_WORD;
    end else if (opword_reg[2:0] == tsto_pkg::CONDITIONAL_TRAP_OP_TWO_WORD) begin
      conditional_trap_op_len = tsto_pkg::STEP_WORD + tsto_pkg::STEP_LONG;
    end else begin
      conditional_trap_op_len = tsto_pkg::STEP_WORD;
    end
    trap_vec = tsto_pkg::VEC_TRAP_BASE + {4'h0, opword_reg[3:0]};
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic setup_phase;
  logic wr_acc;
  logic rd_acc;
  logic idle;
  logic go;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic [31:0] status_word_out;

  always_comb begin
    setup_phase = psel & ~penable;
    wr_acc = psel & penable & pwrite;
    rd_acc = psel & penable & ~pwrite;
    idle = state_reg == tsto_pkg::ST_IDLE;
    go = wr_acc & idle & paddr == tsto_pkg::OFS_CTRL & pwdata[0];
    status_word_out = 32'h0000_0000;
    status_word_out[tsto_pkg::ST_BUSY] = ~idle;
    status_word_out[tsto_pkg::ST_TRAP] = result_reg[0];
    status_word_out[tsto_pkg::ST_ILLEGAL] = result_reg[1];
    status_word_out[tsto_pkg::ST_UNKNOWN] = result_reg[2];
    status_word_out[tsto_pkg::ST_VEC_LSB +: 8] = vec_reg;
    addr_hit = 1'b1;
    unique case (paddr)
      tsto_pkg::OFS_CTRL: rd_mux = 32'h0000_0000;
      tsto_pkg::OFS_STATUS: rd_mux = status_word_out;
      tsto_pkg::OFS_OPWORD: rd_mux = {16'h0000, opword_reg};
      tsto_pkg::OFS_PC: rd_mux = pc_reg;
      tsto_pkg::OFS_SSP: rd_mux = ssp_reg;
      tsto_pkg::OFS_SR: rd_mux = {16'h0000, sr_reg};
      tsto_pkg::OFS_EA: rd_mux = ea_reg;
      tsto_pkg::OFS_DATA: rd_mux = data_opnd_reg;
      tsto_pkg::OFS_VBR: rd_mux = vbr_reg;
      tsto_pkg::OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
      tsto_pkg::OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
      default: begin
        rd_mux = 32'h0000_0000;
        addr_hit = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [tsto_pkg::EV_W-1:0] ev_set;
  logic [7:0] tas_byte;

  always_comb begin
    state_next = state_reg;
    opword_next = opword_reg;
    pc_next = pc_reg;
    ssp_next = ssp_reg;
    sr_next = sr_reg;
    ea_next = ea_reg;
    data_opnd_next = data_opnd_reg;
    vbr_next = vbr_reg;
    saved_pc_next = saved_pc_reg;
    vec_next = vec_reg;
    result_next = result_reg;
    irq_mask_next = irq_mask_reg;
    mem_req_next = mem_req_reg;
    mem_we_next = mem_we_reg;
    mem_lock_next = mem_lock_reg;
    mem_size_next = mem_size_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    ev_set = '0;
    tas_byte = data_opnd_reg[7:0];

    // the answer is prepared in the setup cycle so prdata stands from a flop
    pready_next = 1'b1;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      prdata_next = pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_next = ~addr_hit;
    end

    // context registers are frozen while an instruction runs
    if (wr_acc) begin
      if (paddr == tsto_pkg::OFS_IRQ_MASK) begin
        irq_mask_next = pwdata[tsto_pkg::EV_W-1:0];
      end
      if (idle) begin
        unique case (paddr)
          tsto_pkg::OFS_OPWORD: opword_next = pwdata[15:0];
          tsto_pkg::OFS_PC: pc_next = pwdata;
          tsto_pkg::OFS_SSP: ssp_next = pwdata;
          tsto_pkg::OFS_SR: sr_next = pwdata[15:0];
          tsto_pkg::OFS_EA: ea_next = pwdata;
          tsto_pkg::OFS_DATA: data_opnd_next = pwdata;
          tsto_pkg::OFS_VBR: vbr_next = pwdata;
          default: begin
          end
        endcase
      end
    end

    unique case (state_reg)
      tsto_pkg::ST_IDLE: begin
        if (go) begin
          result_next = 3'h0;
          vec_next = 8'h00;
          if ((is_tas && !tas_legal) || (is_conditional_trap_op && !conditional_trap_op_legal)) begin
            vec_next = tsto_pkg::VEC_ILLEGAL;
            saved_pc_next = pc_reg;
            result_next = 3'h2;
          end else if (is_tas && ea_mode == tsto_pkg::MODE_DREG) begin
            // data register form: the byte lives in the operand register
            sr_next[tsto_pkg::FLAG_N] = tas_byte[7];
            sr_next[tsto_pkg::FLAG_Z] = tas_byte == 8'h00;
            sr_next[tsto_pkg::FLAG_V] = 1'b0;
            sr_next[tsto_pkg::FLAG_C] = 1'b0;
            data_opnd_next[tsto_pkg::TAS_SET_BIT] = 1'b1;
            pc_next = pc_reg + tsto_pkg::STEP_WORD;
            ev_set[tsto_pkg::EV_DONE] = 1'b1;
          end else if (is_tas) begin
            state_next = tsto_pkg::ST_TAS_RD;
            mem_req_next = 1'b1;
            mem_we_next = 1'b0;
            mem_lock_next = 1'b1;
            mem_size_next = tsto_pkg::SIZE_BYTE;
            mem_addr_next = ea_reg;
          end else if (is_trap) begin
            vec_next = trap_vec;
            saved_pc_next = pc_reg + tsto_pkg::STEP_WORD;
            result_next = 3'h1;
          end else if (is_overflow_trap_op || is_conditional_trap_op) begin
            if ((is_overflow_trap_op && sr_reg[tsto_pkg::FLAG_V]) ||
                (is_conditional_trap_op && cond_true(opword_reg[11:8], sr_reg))) begin
              vec_next = tsto_pkg::VEC_CONDITIONAL_TRAP_OP;
              // the saved pc points at the operand words so the handler can read them
              saved_pc_next = pc_reg + tsto_pkg::STEP_WORD;
              result_next = 3'h1;
            end else begin
              pc_next = pc_reg + (is_conditional_trap_op ? conditional_trap_op_len : tsto_pkg::STEP_WORD);
              ev_set[tsto_pkg::EV_DONE] = 1'b1;
            end
          end else begin
            result_next = 3'h4;
            ev_set[tsto_pkg::EV_DONE] = 1'b1;
          end
          // any trap or illegal opword starts the exception stack frame
          if (((is_tas && !tas_legal) || (is_conditional_trap_op && !conditional_trap_op_legal)) || is_trap ||
              (is_overflow_trap_op && sr_reg[tsto_pkg::FLAG_V]) ||
              (is_conditional_trap_op && conditional_trap_op_legal && cond_true(opword_reg[11:8], sr_reg))) begin
            state_next = tsto_pkg::ST_PUSH_FMT;
            ssp_next = ssp_reg - tsto_pkg::STEP_WORD;
            mem_req_next = 1'b1;
            mem_we_next = 1'b1;
            mem_lock_next = 1'b0;
            mem_size_next = tsto_pkg::SIZE_WORD;
            mem_addr_next = ssp_reg - tsto_pkg::STEP_WORD;
            mem_wdata_next = {16'h0000, tsto_pkg::FRAME_FORMAT, 2'b00, vec_next, 2'b00};
          end
        end
      end
      tsto_pkg::ST_TAS_RD: begin
        if (mem_ack) begin
          tas_byte = mem_rdata[7:0];
          sr_next[tsto_pkg::FLAG_N] = tas_byte[7];
          sr_next[tsto_pkg::FLAG_Z] = tas_byte == 8'h00;
          sr_next[tsto_pkg::FLAG_V] = 1'b0;
          sr_next[tsto_pkg::FLAG_C] = 1'b0;
          state_next = tsto_pkg::ST_TAS_WR;
          mem_we_next = 1'b1;
          mem_wdata_next = {24'h000000, tas_byte | 8'h80};
        end
      end
      tsto_pkg::ST_TAS_WR: begin
        if (mem_ack) begin
          // lock falls only with the write, never between read and write
          state_next = tsto_pkg::ST_IDLE;
          mem_req_next = 1'b0;
          mem_we_next = 1'b0;
          mem_lock_next = 1'b0;
          pc_next = pc_reg + tsto_pkg::STEP_WORD;
          ev_set[tsto_pkg::EV_DONE] = 1'b1;
        end
      end
      tsto_pkg::ST_PUSH_FMT: begin
        if (mem_ack) begin
          state_next = tsto_pkg::ST_PUSH_PC;
          ssp_next = ssp_reg - tsto_pkg::STEP_LONG;
          mem_size_next = tsto_pkg::SIZE_LONG;
          mem_addr_next = ssp_reg - tsto_pkg::STEP_LONG;
          mem_wdata_next = saved_pc_reg;
        end
      end
      tsto_pkg::ST_PUSH_PC: begin
        if (mem_ack) begin
          state_next = tsto_pkg::ST_PUSH_SR;
          ssp_next = ssp_reg - tsto_pkg::STEP_WORD;
          mem_size_next = tsto_pkg::SIZE_WORD;
          mem_addr_next = ssp_reg - tsto_pkg::STEP_WORD;
          mem_wdata_next = {16'h0000, sr_reg};
        end
      end
      tsto_pkg::ST_PUSH_SR: begin
        if (mem_ack) begin
          state_next = tsto_pkg::ST_VEC_RD;
          mem_we_next = 1'b0;
          mem_size_next = tsto_pkg::SIZE_LONG;
          mem_addr_next = vbr_reg + {22'h0, vec_reg, 2'b00};
          mem_wdata_next = 32'h0000_0000;
        end
      end
      tsto_pkg::ST_VEC_RD: begin
        if (mem_ack) begin
          state_next = tsto_pkg::ST_IDLE;
          mem_req_next = 1'b0;
          pc_next = mem_rdata;
          ev_set[tsto_pkg::EV_DONE] = 1'b1;
          ev_set[tsto_pkg::EV_TRAP] = result_reg[0];
          ev_set[tsto_pkg::EV_ILLEGAL] = result_reg[1];
        end
      end
    endcase

    // a new event wins over the clearing read in the same cycle
    irq_stat_next = irq_stat_reg;
    if (rd_acc && paddr == tsto_pkg::OFS_IRQ_STAT) begin
      irq_stat_next = '0;
    end
    irq_stat_next = irq_stat_next | ev_set;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tsto_pkg::ST_IDLE;
      opword_reg <= 16'h0000;
      pc_reg <= tsto_pkg::RST_WORD;
      ssp_reg <= tsto_pkg::RST_WORD;
      sr_reg <= tsto_pkg::RST_SR;
      ea_reg <= tsto_pkg::RST_WORD;
      data_opnd_reg <= tsto_pkg::RST_WORD;
      vbr_reg <= tsto_pkg::RST_WORD;
      saved_pc_reg <= tsto_pkg::RST_WORD;
      vec_reg <= 8'h00;
      result_reg <= 3'h0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_lock_reg <= 1'b0;
      mem_size_reg <= 2'h0;
      mem_addr_reg <= tsto_pkg::RST_WORD;
      mem_wdata_reg <= tsto_pkg::RST_WORD;
    end else begin
      state_reg <= state_next;
      opword_reg <= opword_next;
      pc_reg <= pc_next;
      ssp_reg <= ssp_next;
      sr_reg <= sr_next;
      ea_reg <= ea_next;
      data_opnd_reg <= data_opnd_next;
      vbr_reg <= vbr_next;
      saved_pc_reg <= saved_pc_next;
      vec_reg <= vec_next;
      result_reg <= result_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      mem_req_reg <= mem_req_next;
      mem_we_reg <= mem_we_next;
      mem_lock_reg <= mem_lock_next;
      mem_size_reg <= mem_size_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_lock = mem_lock_reg;
  assign mem_size = mem_size_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign irq = irq_reg;

endmodule

// File: hdl/tsto_pkg.sv
// constants for the test-and-set and trap execution unit
// assumes an apb master for control and a byte/word/long memory port that grants a lock
package tsto_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_OPWORD = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_SSP = 8'h10;
  localparam logic [7:0] OFS_SR = 8'h14;
  localparam logic [7:0] OFS_EA = 8'h18;
  localparam logic [7:0] OFS_DATA = 8'h1C;
  localparam logic [7:0] OFS_VBR = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  // reset values
  localparam logic [15:0] RST_SR = 16'h2700;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // condition flag positions inside the status word
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_TRAP = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_UNKNOWN = 3;
  localparam int ST_VEC_LSB = 8;
  // interrupt event bits
  localparam int EV_DONE = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_ILLEGAL = 2;
  localparam int EV_W = 3;
  // opword patterns
  localparam logic [9:0] TAS_MATCH = 10'h12B;
  localparam logic [11:0] TRAP_MATCH = 12'h4E4;
  localparam logic [15:0] OVERFLOW_TRAP_OP_OPWORD = 16'h4E76;
  localparam logic [3:0] CONDITIONAL_TRAP_OP_TOP = 4'h5;
  localparam logic [4:0] CONDITIONAL_TRAP_OP_MID = 5'h1F;
  localparam logic [2:0] CONDITIONAL_TRAP_OP_ONE_WORD = 3'h2;
  localparam logic [2:0] CONDITIONAL_TRAP_OP_TWO_WORD = 3'h3;
  localparam logic [2:0] CONDITIONAL_TRAP_OP_NO_WORD = 3'h4;
  localparam int TAS_SET_BIT = 7;
  // operand modes
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] REG_ABS_LONG = 3'h1;
  // vectors and stack steps
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  localparam logic [7:0] VEC_CONDITIONAL_TRAP_OP = 8'h07;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [3:0] FRAME_FORMAT = 4'h0;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  // memory access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TAS_RD, ST_TAS_WR, ST_PUSH_FMT, ST_PUSH_PC, ST_PUSH_SR, ST_VEC_RD
  } tsto_state_type;
endpackage

// File: sim/tsto_mem_model.sv
// behavioural memory on the far side of the unit's memory port
// assumes addresses below 256; bytes are big-endian, as the stack frames are
`timescale 1ns/1ps
module tsto_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_wait,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [7:0] mem [0:255];
  logic [3:0] cnt;
  logic [31:0] r;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  // a locked pair is served back to back; no other master can split it here
  always @(posedge pclk or negedge presetn) begin
    r = 32'h0;
    for (int i = 0; i < 4; i++) r = (i < (1 << mem_size)) ? {r[23:0], mem[mem_addr[7:0] + i[7:0]]} : r;
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt == mem_wait) begin
      mem_ack <= 1'b1;
      cnt <= 4'h0;
      mem_rdata <= r;
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      // read data is not held past its ack, so a late sample shows garbage
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_ack && mem_we)
        for (int i = 0; i < 4; i++)
          if (i < (1 << mem_size)) mem[mem_addr[7:0] + i[7:0]] <= mem_wdata[8 * ((1 << mem_size) - 1 - i) +: 8];
    end
  end
endmodule

// File: sim/tsto_unit_sva.sv
// memory port checker for the test-and-set and trap unit
// assumes it is bound to tsto_unit and sees only its ports
`timescale 1ns/1ps
module tsto_unit_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_lock,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_TAS_PAIR: assert property (
    mem_req && mem_ack && mem_lock && !mem_we |=> mem_req && mem_we && mem_lock && $stable(mem_addr))
    else $error("locked read not followed by its write");
  AST_TAS_DATA: assert property (
    mem_req && mem_ack && mem_lock && !mem_we |=> mem_wdata[7:0] == ($past(mem_rdata[7:0]) | 8'h80))
    else $error("written byte is not the read byte with bit 7 set");
  AST_TAS_BYTE: assert property (mem_req && mem_lock |-> mem_size == tsto_pkg::SIZE_BYTE)
    else $error("locked access is not a byte");
  AST_LOCK_RD: assert property ($rose(mem_lock) |-> mem_req && !mem_we)
    else $error("locked sequence does not start with a read");
  AST_UNLOCK: assert property (mem_req && mem_ack && mem_lock && mem_we |=> !mem_lock)
    else $error("lock held after the write completed");
  AST_REQ_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_lock))
    else $error("request changed before its ack");
  AST_PUSH_PC: assert property (
    (mem_req && mem_ack && mem_we && mem_size == tsto_pkg::SIZE_WORD) ##1 (mem_req && mem_we) |->
    mem_size == tsto_pkg::SIZE_LONG && mem_addr == $past(mem_addr) - 32'h4 && $past(mem_wdata[15:12]) == 4'h0)
    else $error("format word not followed by counter push four below");
  AST_PUSH_SR: assert property (
    mem_req && mem_ack && mem_we && mem_size == tsto_pkg::SIZE_LONG |=>
    mem_req && mem_we && mem_size == tsto_pkg::SIZE_WORD && mem_addr == $past(mem_addr) - 32'h2)
    else $error("counter push not followed by status push two below");
endmodule
bind tsto_unit tsto_unit_sva tsto_unit_sva_inst (.pclk, .presetn, .mem_req, .mem_we, .mem_lock, .mem_size,
  .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

// File: sim/tsto_unit_tb_top.sv
// self-checking bench for the test-and-set and trap unit
// assumes the checker binds itself and the memory model starts with byte i holding i
`timescale 1ns/1ps
module tsto_unit_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] mem_wait = 4'h0;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, rd, e;
  logic pready, pslverr, mem_req, mem_we, mem_lock, mem_ack, irq, err;
  logic [1:0] mem_size;
  logic [3:0] f;
  logic [2:0] m;
  logic [15:0] tas_ok [7] = '{16'h4AD0, 16'h4AD9, 16'h4AE2, 16'h4AEB, 16'h4AF4, 16'h4AF8, 16'h4AF9};
  logic [15:0] tas_bad [4] = '{16'h4AC8, 16'h4AFA, 16'h4AFB, 16'h4AFC};
  int error_cnt = 0;
  int check_count = 0;
  initial forever #50 pclk = ~pclk;
  tsto_unit tsto_unit_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_req, .mem_we, .mem_lock, .mem_size, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .irq);
  tsto_mem_model tsto_mem_model_inst (.pclk, .presetn, .mem_req, .mem_we, .mem_size, .mem_addr,
    .mem_wdata, .mem_wait, .mem_ack, .mem_rdata);
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 20) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // irq is registered, so look at it mid-cycle and realign to the rising edge
  task automatic irqchk(input logic exp);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge pclk);
  endtask
  task automatic run(input logic [31:0] sr, input logic [15:0] opw);
    int n;
    n = 0;
    apb(1'b1, tsto_pkg::OFS_PC, 32'h1000);
    apb(1'b1, tsto_pkg::OFS_SSP, 32'h100);
    apb(1'b1, tsto_pkg::OFS_SR, sr);
    apb(1'b1, tsto_pkg::OFS_OPWORD, {16'h0, opw});
    apb(1'b1, tsto_pkg::OFS_CTRL, 32'h1);
    do begin
      apb(1'b0, tsto_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[tsto_pkg::ST_BUSY] !== 1'b0 && n < 50);
    if (n == 50) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  function automatic logic [31:0] mw(input logic [7:0] a, input int n);
    mw = 32'h0;
    for (int i = 0; i < n; i++) mw = {mw[23:0], tsto_mem_model_inst.mem[a + i[7:0]]};
  endfunction
  // flags arrive as n z v c, the order of the low status bits
  function automatic logic cond(input logic [3:0] c, input logic [3:0] fl);
    case (c[3:1])
      3'h0: cond = 1'b1;
      3'h1: cond = !fl[0] && !fl[2];
      3'h2: cond = !fl[0];
      3'h3: cond = !fl[2];
      3'h4: cond = !fl[1];
      3'h5: cond = !fl[3];
      3'h6: cond = fl[3] == fl[1];
      default: cond = fl[3] == fl[1] && !fl[2];
    endcase
    return c[0] ? !cond : cond;
  endfunction
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(tsto_pkg::OFS_SR, {16'h0, tsto_pkg::RST_SR});
    rchk(tsto_pkg::OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, tsto_pkg::OFS_EA, 32'h40);
    apb(1'b1, tsto_pkg::OFS_IRQ_MASK, 32'h2);
    foreach (tas_ok[i]) begin
      mem_wait <= i[3:0];
      tsto_mem_model_inst.mem[8'h40] = 8'h00;
      run(32'h2713, tas_ok[i]);
      chk(mw(8'h40, 1), 32'h80);
      rchk(tsto_pkg::OFS_SR, 32'h2714);
    end
    apb(1'b1, tsto_pkg::OFS_DATA, 32'h05);
    run(32'h2700, 16'h4AC3);
    rchk(tsto_pkg::OFS_DATA, 32'h85);
    rchk(tsto_pkg::OFS_SR, 32'h2700);
    // a byte with bit 7 already set: negative flag and an unchanged write-back
    tsto_mem_model_inst.mem[8'h40] = 8'hC5;
    run(32'h2703, 16'h4AD0);
    chk(mw(8'h40, 1), 32'hC5);
    rchk(tsto_pkg::OFS_SR, 32'h2708);
    // an opword that none of the four instructions claims only reports itself
    run(32'h2700, 16'h0000);
    chk({28'h0, rd[3:0]}, 32'h8);
    rchk(tsto_pkg::OFS_PC, 32'h1000);
    foreach (tas_bad[i]) begin
      run(32'h2700, tas_bad[i]);
      chk({16'h0, rd[15:8], 7'h0, rd[tsto_pkg::ST_ILLEGAL]}, 32'h401);
      rchk(tsto_pkg::OFS_PC, mw(8'h10, 4));
    end
    irqchk(1'b0);
    for (int s = 0; s < 16; s++) begin
      run(32'h2705, {12'h4E4, s[3:0]});
      e = 32'h80 + {26'h0, s[3:0], 2'h0};
      chk(mw(8'hFE, 2), e);
      chk(mw(8'hFA, 4), 32'h1002);
      chk(mw(8'hF8, 2), 32'h2705);
      rchk(tsto_pkg::OFS_SSP, 32'hF8);
      rchk(tsto_pkg::OFS_PC, mw(e[7:0], 4));
      rchk(tsto_pkg::OFS_SR, 32'h2705);
    end
    for (int i = 0; i < 32; i++) begin
      f = i[4] ? ~i[3:0] : i[3:0];
      run(32'h2700 | {28'h0, f}, {4'h5, i[3:0], 8'hFC});
      rchk(tsto_pkg::OFS_PC, cond(i[3:0], f) ? mw(8'h1C, 4) : 32'h1002);
      rchk(tsto_pkg::OFS_SR, 32'h2700 | {28'h0, f});
    end
    for (int i = 0; i < 10; i++) begin
      m = 3'(i / 2 + 1);
      run(32'h2700, {4'h5, 3'h0, ~i[0], 5'h1F, m});
      if (m == 3'h1 || m == 3'h5) e = mw(8'h10, 4);
      else if (i[0]) e = mw(8'h1C, 4);
      else e = (m == 3'h4) ? 32'h1002 : 32'h1000 + {28'h0, m, 1'b0};
      rchk(tsto_pkg::OFS_PC, e);
      if (i[0] && m != 3'h1 && m != 3'h5) chk(mw(8'hFA, 4), 32'h1002);
    end
    for (int v = 0; v < 2; v++) begin
      run(32'h2700 | {30'h0, v[0], 1'b0}, tsto_pkg::OVERFLOW_TRAP_OP_OPWORD);
      rchk(tsto_pkg::OFS_PC, v[0] ? mw(8'h1C, 4) : 32'h1002);
    end
    irqchk(1'b1);
    rchk(tsto_pkg::OFS_IRQ_STAT, 32'h7);
    irqchk(1'b0);
    give_verdict;
  end
endmodule
